// File: hdl/pff_flow_ctrl.sv
// packet fifo flow control: availability flags and burst engines
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module pff_burst_eng (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic multi_i,
    input wire logic nolimit_i,
    input wire logic run_i,
    input wire logic hold_i,
    input wire logic [pff_pkg::LVL_W-1:0] limit_i,
    input wire logic [pff_pkg::NCH-1:0] start_i,
    input wire logic [pff_pkg::NCH-1:0] more_i,
    output logic xfer_o,
    output logic [pff_pkg::CH_W-1:0] ch_o,
    output logic busy_o
);
    import pff_pkg::*;
    logic busy_reg;
    logic xfer_reg;
    logic [CH_W-1:0] ch_reg;
    logic [LVL_W-1:0] cnt_reg;
    logic [CH_W-1:0] pick;
    logic [CH_W-1:0] idx;
    logic pick_ok;
    logic [LVL_W:0] cnt_inc;
    logic over;
    logic can;
    logic fin;

    // search starts after the last served channel
    always_comb begin
        pick = '0;
        pick_ok = 1'b0;
        idx = '0;
        if (multi_i) begin
            for (int i = NCH; i >= 1; i--) begin
                idx = ch_reg + CH_W'(i);
                if (start_i[idx]) begin
                    pick = idx;
                    pick_ok = 1'b1;
                end
            end
        end else begin
            pick_ok = start_i[0];
        end
    end

    always_comb begin
        cnt_inc = {1'b0, cnt_reg} + {1'b0, WORD_BYTES};
        over = cnt_inc > {1'b0, limit_i};
        can = busy_reg & run_i & more_i[ch_reg] & ~hold_i
            & (nolimit_i | ~over);
        fin = busy_reg & (~more_i[ch_reg] | hold_i | (~nolimit_i & over));
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_reg <= 1'b0;
            xfer_reg <= 1'b0;
            ch_reg <= '0;
            cnt_reg <= '0;
        end else if (ce_i) begin
            xfer_reg <= can;
            if (can) begin
                cnt_reg <= cnt_inc[LVL_W-1:0];
            end
            // run low pauses a burst but never ends it
            if (!busy_reg && run_i && pick_ok) begin
                busy_reg <= 1'b1;
                ch_reg <= pick;
                cnt_reg <= '0;
            end else if (fin) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign xfer_o = xfer_reg;
    assign ch_o = ch_reg;
    assign busy_o = busy_reg;

    property p_burst_cap;
        @(posedge clk_i) disable iff (!reset_n_i)
        (xfer_reg && !nolimit_i) |-> (cnt_reg <= limit_i);
    endproperty
    a_burst_cap: assert property (p_burst_cap)
        else $error("burst byte count above limit");

    property p_no_xfer_idle;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && !busy_reg) |=> !xfer_reg;
    endproperty
    a_no_xfer_idle: assert property (p_no_xfer_idle)
        else $error("transfer without an arbitrated channel");
endmodule

////////////////////////////////////////////////////////////////////////////
module pff_flow_ctrl (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [pff_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pff_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pff_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic [pff_pkg::NCH-1:0][pff_pkg::LVL_W-1:0] tx_fill_i,
    input wire logic [pff_pkg::CH_W-1:0] tx_poll_adr_i,
    input wire logic [pff_pkg::CH_W-1:0] tx_sel_adr_i,
    output logic tx_poll_avail_o,
    output logic tx_sel_avail_o,
    output logic [pff_pkg::NCH-1:0] tx_direct_avail_o,
    input wire logic [pff_pkg::NCH-1:0][pff_pkg::LVL_W-1:0] rx_fill_i,
    input wire logic [pff_pkg::NCH-1:0] rx_eop_i,
    input wire logic rx_enable_n_i,
    output logic rx_pop_o,
    output logic [pff_pkg::CH_W-1:0] rx_ch_o,
    input wire logic [pff_pkg::NCH-1:0][pff_pkg::LVL_W-1:0] ltx_fill_i,
    input wire logic [pff_pkg::NCH-1:0] ltx_eop_i,
    input wire logic ltx_poll_avail_i,
    input wire logic ltx_sel_avail_i,
    input wire logic [pff_pkg::NCH-1:0] ltx_direct_avail_i,
    output logic ltx_push_o,
    output logic [pff_pkg::CH_W-1:0] ltx_ch_o,
    input wire logic [pff_pkg::NCH-1:0][pff_pkg::LVL_W-1:0] lrx_fill_i,
    input wire logic lrx_poll_avail_i,
    input wire logic [pff_pkg::NCH-1:0] lrx_direct_avail_i,
    output logic lrx_pull_o,
    output logic [pff_pkg::CH_W-1:0] lrx_ch_o
);
    import pff_pkg::*;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [LVL_W-1:0] thr_reg;
    logic [LVL_W-1:0] burst_reg;
    logic [LVL_W-1:0] rburst_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    logic [NCH-1:0] tx_space_reg;
    logic [NCH-1:0] lrx_full_reg;
    logic tx_poll_reg;
    logic tx_sel_reg;
    logic [NCH-1:0] tx_dir_reg;
    logic [LVL_W-1:0] af_reg;
    logic [NCH-1:0][LVL_W-1:0] tx_free;
    logic [NCH-1:0][LVL_W-1:0] lrx_free;
    logic [NCH-1:0] rx_ne;
    logic [NCH-1:0] rx_more;
    logic [NCH-1:0] ltx_start;
    logic [NCH-1:0] ltx_more;
    logic [NCH-1:0] lrx_avail;
    logic [NCH-1:0] lrx_start;
    logic [NCH-1:0] lrx_more;
    logic polled;
    logic multi;
    logic [CH_W-1:0] poll_adr_s;
    logic [CH_W-1:0] sel_adr_s;
    logic renb_n_s;
    logic ltx_pa_s;
    logic ltx_sa_s;
    logic [NCH-1:0] ltx_da_s;
    logic lrx_pa_s;
    logic [NCH-1:0] lrx_da_s;
    logic ltx_busy;
    logic rx_busy;
    logic lrx_busy;
    logic ltx_sp_cur;
    logic [LVL_W:0] af_sum;
    logic ltx_hold;
    logic [DATA_W-1:0] rd_mux;

    assign polled = ctrl_reg[CTRL_POLLED_BIT];
    assign multi = ctrl_reg[CTRL_MULTI_BIT];

    ////////////////////////////////////////////////////////////////////////
    // register port, read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= CTRL_RST;
            thr_reg <= THR_RST;
            burst_reg <= BURST_RST;
            rburst_reg <= RBURST_RST;
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                ADR_CTRL: ctrl_reg <= reg_wdata_i[CTRL_W-1:0];
                ADR_THR: thr_reg <= reg_wdata_i[LVL_W-1:0];
                ADR_BURST: burst_reg <= reg_wdata_i[LVL_W-1:0];
                ADR_RBURST: rburst_reg <= reg_wdata_i[LVL_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_mux = '0;
        case (reg_addr_i)
            ADR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
            ADR_THR: rd_mux[LVL_W-1:0] = thr_reg;
            ADR_BURST: rd_mux[LVL_W-1:0] = burst_reg;
            ADR_RBURST: rd_mux[LVL_W-1:0] = rburst_reg;
            ADR_STAT: begin
                rd_mux[STAT_SPACE_LSB +: NCH] = tx_space_reg;
                rd_mux[STAT_NE_LSB +: NCH] = rx_ne;
                rd_mux[STAT_FULL_LSB +: NCH] = lrx_full_reg;
                rd_mux[STAT_BUSY_LSB +: 3] = {lrx_busy, ltx_busy, rx_busy};
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
        end else if (ce_i) begin
            rdata_reg <= reg_rd_i ? rd_mux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins from the far device, two flops before any use
    assign pin_raw = {tx_poll_adr_i, tx_sel_adr_i, rx_enable_n_i,
        ltx_poll_avail_i, ltx_sel_avail_i, ltx_direct_avail_i,
        lrx_poll_avail_i, lrx_direct_avail_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= PIN_RST;
            sync2_reg <= PIN_RST;
        end else if (ce_i) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    assign {poll_adr_s, sel_adr_s, renb_n_s, ltx_pa_s, ltx_sa_s, ltx_da_s,
        lrx_pa_s, lrx_da_s} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////
    // per-channel level compares, evaluated every cycle
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            tx_free[c] = FIFO_BYTES - tx_fill_i[c];
            lrx_free[c] = FIFO_BYTES - lrx_fill_i[c];
            rx_ne[c] = (rx_fill_i[c] > thr_reg) | rx_eop_i[c];
            rx_more[c] = (rx_fill_i[c] != '0);
            ltx_start[c] = ((ltx_fill_i[c] > thr_reg) | ltx_eop_i[c])
                & (polled ? ltx_pa_s : ltx_da_s[c]);
            ltx_more[c] = (ltx_fill_i[c] != '0);
            lrx_avail[c] = polled ? lrx_pa_s : lrx_da_s[c];
            lrx_start[c] = ~lrx_full_reg[c] & lrx_avail[c];
            lrx_more[c] = lrx_avail[c] & (lrx_free[c] >= WORD_BYTES);
        end
    end

    // hysteresis: tx space sets at threshold, clears below burst; link rx full sets below burst, clears at threshold
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_space_reg <= '0;
            lrx_full_reg <= '1;
        end else if (ce_i) begin
            for (int c = 0; c < NCH; c++) begin
                if (tx_free[c] >= thr_reg) begin
                    tx_space_reg[c] <= 1'b1;
                end else if (tx_free[c] < burst_reg) begin
                    tx_space_reg[c] <= 1'b0;
                end
                if (lrx_free[c] < burst_reg) begin
                    lrx_full_reg[c] <= 1'b1;
                end else if (lrx_free[c] >= thr_reg) begin
                    lrx_full_reg[c] <= 1'b0;
                end
            end
        end
    end

    // only the active status style drives, the other stays low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_poll_reg <= 1'b0;
            tx_sel_reg <= 1'b0;
            tx_dir_reg <= '0;
        end else if (ce_i) begin
            tx_poll_reg <= polled & tx_space_reg[poll_adr_s];
            tx_sel_reg <= polled & tx_space_reg[sel_adr_s];
            tx_dir_reg <= polled ? '0 : tx_space_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // almost-full budget; includes the word already decided last cycle
    assign ltx_sp_cur = polled ? ltx_sa_s : ltx_da_s[ltx_ch_o];
    assign af_sum = {1'b0, af_reg} + {1'b0, WORD_BYTES}
        + (ltx_push_o ? {1'b0, WORD_BYTES} : '0);
    assign ltx_hold = ~ltx_sp_cur & (af_sum > {1'b0, rburst_reg});

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            af_reg <= '0;
        end else if (ce_i) begin
            if (!ltx_busy || ltx_sp_cur) begin
                af_reg <= '0;
            end else if (ltx_push_o) begin
                af_reg <= af_reg + WORD_BYTES;
            end
        end
    end

    // single-channel receive bursts rely on software keeping burst small
    pff_burst_eng u_rx_eng (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .multi_i(multi),
        .nolimit_i(1'b0),
        .run_i(~renb_n_s),
        .hold_i(1'b0),
        .limit_i(burst_reg),
        .start_i(rx_ne),
        .more_i(rx_more),
        .xfer_o(rx_pop_o),
        .ch_o(rx_ch_o),
        .busy_o(rx_busy)
    );

    pff_burst_eng u_ltx_eng (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .multi_i(multi),
        .nolimit_i(~multi),
        .run_i(1'b1),
        .hold_i(ltx_hold),
        .limit_i(burst_reg),
        .start_i(ltx_start),
        .more_i(ltx_more),
        .xfer_o(ltx_push_o),
        .ch_o(ltx_ch_o),
        .busy_o(ltx_busy)
    );

    pff_burst_eng u_lrx_eng (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .multi_i(multi),
        .nolimit_i(1'b0),
        .run_i(1'b1),
        .hold_i(1'b0),
        .limit_i(burst_reg),
        .start_i(lrx_start),
        .more_i(lrx_more),
        .xfer_o(lrx_pull_o),
        .ch_o(lrx_ch_o),
        .busy_o(lrx_busy)
    );

    assign reg_rdata_o = rdata_reg;
    assign tx_poll_avail_o = tx_poll_reg;
    assign tx_sel_avail_o = tx_sel_reg;
    assign tx_direct_avail_o = tx_dir_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_tx_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && tx_free[0] >= thr_reg) |=> tx_space_reg[0];
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("tx space not shown at threshold");

    property p_tx_clr;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && tx_free[0] < burst_reg && tx_free[0] < thr_reg)
            |=> !tx_space_reg[0];
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("tx space kept below burst");

    property p_tx_direct;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && !polled) |=> (tx_direct_avail_o == $past(tx_space_reg));
    endproperty
    a_tx_direct: assert property (p_tx_direct)
        else $error("direct outputs disagree with space flags");

    property p_tx_polled;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && !polled) |=> (!tx_poll_avail_o && !tx_sel_avail_o);
    endproperty
    a_tx_polled: assert property (p_tx_polled)
        else $error("polled outputs driven in direct mode");

    property p_rx_renb;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rx_pop_o && $past(ce_i)) |-> !$past(renb_n_s);
    endproperty
    a_rx_renb: assert property (p_rx_renb)
        else $error("rx transfer while enable pin high");

    property p_lrx_full;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && lrx_free[0] < burst_reg) |=> lrx_full_reg[0];
    endproperty
    a_lrx_full: assert property (p_lrx_full)
        else $error("link rx full flag not set below burst");

    property p_lrx_clear;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ce_i && lrx_free[0] >= thr_reg && lrx_free[0] >= burst_reg)
            |=> !lrx_full_reg[0];
    endproperty
    a_lrx_clear: assert property (p_lrx_clear)
        else $error("link rx full flag not cleared at threshold");

    property p_ltx_af;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ltx_busy && !ltx_sp_cur) |-> (af_reg <= rburst_reg);
    endproperty
    a_ltx_af: assert property (p_ltx_af)
        else $error("remote burst budget exceeded");
endmodule

// File: inc/pff_pkg.sv
// shared constants for the packet fifo flow-control block
// Operation
// - One fifo per channel; tx space shown when free bytes reach threshold.
// - Polled mode reports tx space on the polled and selected outputs.
// - Direct mode reports each channel's tx space on its direct output.
// - Tx space drops when free bytes fall below the burst setting.
// - Rx not-empty when content exceeds threshold or holds an end of packet.
// - Rx bursts start only while the receive enable pin is low.
// - No burst moves more bytes than the burst setting, except link tx bursts in single-channel mode.
// - Multi-channel mode re-arbitrates round robin after each burst.
// - Burst setting should not exceed the threshold setting.
// - Single-channel receive bursts should use the smallest burst value.
// - Link tx drains channels above threshold or holding an end of packet once the far end shows space.
// - Link tx ignores the burst setting in single-channel mode.
// - Link rx full flag clears when free bytes reach the threshold.
// - Link rx sees far data from polled or direct available inputs.
// - Link rx full flag sets when free bytes drop below burst.
package pff_pkg;
    localparam int NCH = 4;
    localparam int CH_W = 2;
    localparam int LVL_W = 13;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // bytes moved per transfer cycle and bytes held by each channel fifo
    localparam logic [LVL_W-1:0] WORD_BYTES = 13'h0004;
    localparam logic [LVL_W-1:0] FIFO_BYTES = 13'h1000;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_THR = 8'h04;
    localparam logic [ADDR_W-1:0] ADR_BURST = 8'h08;
    localparam logic [ADDR_W-1:0] ADR_RBURST = 8'h0C;
    localparam logic [ADDR_W-1:0] ADR_STAT = 8'h10;
    localparam int CTRL_POLLED_BIT = 0;
    localparam int CTRL_MULTI_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;
    // burst kept below threshold by default
    localparam logic [LVL_W-1:0] THR_RST = 13'h0100;
    localparam logic [LVL_W-1:0] BURST_RST = 13'h0040;
    localparam logic [LVL_W-1:0] RBURST_RST = 13'h0010;
    localparam int STAT_SPACE_LSB = 0;
    localparam int STAT_NE_LSB = 4;
    localparam int STAT_FULL_LSB = 8;
    localparam int STAT_BUSY_LSB = 12;
    // pin bundle layout for the input synchroniser
    localparam int PIN_W = 16;
    // receive enable pin idles high, so its synchroniser resets high
    localparam logic [PIN_W-1:0] PIN_RST = 16'h0800;
endpackage

// File: testbench/pff_far_model.sv
// far-side packet interface device model driving the status pins
`timescale 1ns/1ps
module pff_far_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic accept_i,
    input wire logic [pff_pkg::NCH-1:0] space_i,
    input wire logic [pff_pkg::NCH-1:0] data_i,
    output logic rx_enable_n_o,
    output logic ltx_poll_avail_o,
    output logic ltx_sel_avail_o,
    output logic [pff_pkg::NCH-1:0] ltx_direct_avail_o,
    output logic lrx_poll_avail_o,
    output logic [pff_pkg::NCH-1:0] lrx_direct_avail_o
);
    import pff_pkg::*;
    // pins change just after the edge, like a real registered far end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_enable_n_o <= 1'b1;
            ltx_poll_avail_o <= 1'b0;
            ltx_sel_avail_o <= 1'b0;
            ltx_direct_avail_o <= '0;
            lrx_poll_avail_o <= 1'b0;
            lrx_direct_avail_o <= '0;
        end else begin
            rx_enable_n_o <= !accept_i;
            // polled mode only ever shows channel 0 status here
            ltx_poll_avail_o <= space_i[0];
            ltx_sel_avail_o <= space_i[0];
            ltx_direct_avail_o <= space_i;
            lrx_poll_avail_o <= data_i[0];
            lrx_direct_avail_o <= data_i;
        end
    end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the packet fifo flow-control block
`timescale 1ns/1ps
module tb_top;
    import pff_pkg::*;
    logic clk_i = 0;
    logic reset_n_i = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 0;
    logic rd = 0;
    logic [DATA_W-1:0] rdata;
    logic [NCH-1:0][LVL_W-1:0] tx_fill = '0, rx_fill = '0;
    logic [NCH-1:0][LVL_W-1:0] ltx_fill = '0, lrx_fill = '0;
    logic [NCH-1:0] rx_eop = '0, ltx_eop = '0, space = '0, data = '0;
    logic [CH_W-1:0] poll_adr = '0, sel_adr = '0;
    logic accept = 0;
    logic ce = 1;
    logic renb_n, lpa, lsa, rpa;
    logic [NCH-1:0] ldav, rdav, dtpa, rx_seen, lrx_seen, ltx_seen;
    logic tpa, tsa, pop, push, pull, rx_prev, ltx_prev;
    logic [CH_W-1:0] rx_ch, ltx_ch, lrx_ch, rx_lch;
    int num_errors = 0, n_compared = 0, cyc = 0, mark;
    int rx_cnt, rx_run, rx_max, rr_bad, ltx_cnt, ltx_run, ltx_max, lrx_cnt;
    logic [DATA_W-1:0] d;

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    pff_far_model far (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .accept_i(accept), .space_i(space), .data_i(data),
        .rx_enable_n_o(renb_n), .ltx_poll_avail_o(lpa),
        .ltx_sel_avail_o(lsa), .ltx_direct_avail_o(ldav),
        .lrx_poll_avail_o(rpa), .lrx_direct_avail_o(rdav));

    pff_flow_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_fill_i(tx_fill),
        .tx_poll_adr_i(poll_adr), .tx_sel_adr_i(sel_adr),
        .tx_poll_avail_o(tpa), .tx_sel_avail_o(tsa),
        .tx_direct_avail_o(dtpa), .rx_fill_i(rx_fill), .rx_eop_i(rx_eop),
        .rx_enable_n_i(renb_n), .rx_pop_o(pop), .rx_ch_o(rx_ch),
        .ltx_fill_i(ltx_fill), .ltx_eop_i(ltx_eop),
        .ltx_poll_avail_i(lpa), .ltx_sel_avail_i(lsa),
        .ltx_direct_avail_i(ldav), .ltx_push_o(push), .ltx_ch_o(ltx_ch),
        .lrx_fill_i(lrx_fill), .lrx_poll_avail_i(rpa),
        .lrx_direct_avail_i(rdav), .lrx_pull_o(pull), .lrx_ch_o(lrx_ch));

    ////////////////////////////////////////////////////////////////////////
    // pulse monitors, sampled mid-cycle where outputs are settled
    // a new burst on the same channel breaks round robin
    always @(negedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
        if (pop === 1'b1) begin
            rx_cnt++;
            rx_seen[rx_ch] = 1'b1;
            if (rx_prev === 1'b1 && rx_ch === rx_lch) begin
                rx_run++;
            end else begin
                if (rx_cnt > 1 && rx_ch === rx_lch) rr_bad++;
                rx_run = 1;
            end
            if (rx_run > rx_max) rx_max = rx_run;
            rx_lch = rx_ch;
        end
        rx_prev = pop;
        if (push === 1'b1) begin
            ltx_cnt++;
            ltx_seen[ltx_ch] = 1'b1;
            ltx_run = (ltx_prev === 1'b1) ? ltx_run + 1 : 1;
            if (ltx_run > ltx_max) ltx_max = ltx_run;
        end
        ltx_prev = push;
        if (pull === 1'b1) begin
            lrx_cnt++;
            lrx_seen[lrx_ch] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic ok(input logic c, input string msg);
        chk({31'h0, c}, 32'h1, msg);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        // read data stand in this cycle; take them at its closing edge
        @(posedge clk_i);
        v = rdata;
    endtask

    task automatic clr_mon();
        rx_cnt = 0;
        rx_run = 0;
        rx_max = 0;
        rr_bad = 0;
        rx_seen = '0;
        ltx_cnt = 0;
        ltx_run = 0;
        ltx_max = 0;
        ltx_seen = '0;
        lrx_cnt = 0;
        lrx_seen = '0;
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clr_mon();
        for (int c = 0; c < NCH; c++) begin
            tx_fill[c] = FIFO_BYTES; // no space anywhere at start
            lrx_fill[c] = FIFO_BYTES;
        end
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // register reset values, unmapped place, write then read back
        reg_rd(ADR_CTRL, d);
        chk(d, 32'h3, "ctrl");
        reg_rd(ADR_THR, d);
        chk(d, 32'h100, "thr");
        reg_rd(ADR_BURST, d);
        chk(d, 32'h40, "burst");
        reg_rd(ADR_RBURST, d);
        chk(d, 32'h10, "rburst");
        reg_wr(8'h14, 32'hFFFF);
        reg_rd(8'h14, d);
        chk(d, 32'h0, "unmapped");
        // a frozen block must ignore the write strobe
        ce <= 1'b0;
        reg_wr(ADR_THR, 32'h0);
        ce <= 1'b1;
        reg_rd(ADR_THR, d);
        chk(d, 32'h100, "ce low");
        reg_wr(ADR_CTRL, 32'h2);
        reg_rd(ADR_CTRL, d);
        chk(d, 32'h2, "ctrl wr");
        $display("test regs done");
        // direct mode tx space with hysteresis between burst and threshold
        tx_fill[2] <= FIFO_BYTES - 13'h0100;
        waitc(4);
        chk(dtpa, 4'h4, "dtpa set");
        tx_fill[2] <= FIFO_BYTES - 13'h0040;
        waitc(4);
        chk(dtpa, 4'h4, "dtpa hold");
        tx_fill[2] <= FIFO_BYTES - 13'h003C;
        waitc(4);
        chk(dtpa, 4'h0, "dtpa clr");
        tx_fill[2] <= FIFO_BYTES - 13'h0080;
        waitc(4);
        chk(dtpa, 4'h0, "dtpa stay");
        // polled mode
        reg_wr(ADR_CTRL, 32'h3);
        tx_fill[2] <= FIFO_BYTES - 13'h0100;
        poll_adr <= 2'h2;
        sel_adr <= 2'h2;
        waitc(8);
        chk({tpa, tsa, dtpa}, 6'h30, "polled");
        sel_adr <= 2'h1;
        waitc(8);
        chk({tpa, tsa}, 2'h2, "sel other");
        tx_fill[2] <= FIFO_BYTES - 13'h003C;
        waitc(4);
        ok(!tpa, "poll clr");
        $display("test tx sink done");
        // rx source: eop channel and threshold channel, enable held back
        reg_wr(ADR_BURST, 32'h8);
        rx_fill[1] <= 13'h0200;
        rx_fill[3] <= 13'h0008;
        rx_eop[3] <= 1'b1;
        waitc(20);
        clr_mon();
        waitc(20);
        chk(rx_cnt, 0, "pop w/o enable");
        accept <= 1'b1;
        waitc(80);
        ok(rx_cnt > 4, "rx pops");
        chk(rx_seen, 4'hA, "rx channels");
        ok(rx_max <= 2, "rx burst");
        chk(rr_bad, 0, "round robin");
        accept <= 1'b0;
        rx_fill <= '0;
        rx_eop <= '0;
        $display("test rx source done");
        // link tx, direct multi: burst limit, then almost full
        reg_wr(ADR_CTRL, 32'h2);
        reg_wr(ADR_RBURST, 32'h8);
        ltx_fill[0] <= 13'h0200;
        space <= 4'h1;
        waitc(10);
        clr_mon();
        waitc(40);
        ok(ltx_cnt > 4, "ltx push");
        ok(ltx_max <= 2, "ltx burst");
        chk(ltx_seen, 4'h1, "ltx channel");
        reg_wr(ADR_BURST, 32'h40);
        waitc(20);
        space <= 4'h0;
        mark = ltx_cnt;
        // pin sync latency plus two remote-burst words
        waitc(30);
        ok(ltx_cnt - mark <= 6, "remote burst");
        mark = ltx_cnt;
        waitc(20);
        chk(ltx_cnt - mark, 0, "ltx stopped");
        // single mode ignores the burst setting
        reg_wr(ADR_CTRL, 32'h0);
        reg_wr(ADR_BURST, 32'h8);
        space <= 4'h1;
        waitc(10);
        clr_mon();
        waitc(40);
        ok(ltx_max > 2, "single no limit");
        space <= 4'h0;
        ltx_fill <= '0;
        $display("test link tx done");
        // link rx: full flags from reset, clear once space reaches threshold
        reg_wr(ADR_CTRL, 32'h3);
        data <= 4'h1;
        waitc(10);
        clr_mon();
        waitc(20);
        chk(lrx_cnt, 0, "pull when full");
        reg_rd(ADR_STAT, d);
        chk(d[11:8], 4'hF, "full flags");
        lrx_fill <= '0;
        waitc(30);
        ok(lrx_cnt > 0, "polled pull");
        reg_rd(ADR_STAT, d);
        chk(d[11:8], 4'h0, "full clr");
        reg_wr(ADR_CTRL, 32'h2);
        data <= 4'h4;
        waitc(10);
        clr_mon();
        waitc(30);
        chk(lrx_seen, 4'h4, "direct pull");
        lrx_fill[2] <= FIFO_BYTES - 13'h0004;
        waitc(10);
        clr_mon();
        waitc(20);
        chk(lrx_cnt, 0, "refull");
        $display("test link rx done");
        end_of_test();
    end
endmodule
